/* verilog/lp_state_pkg.sv */
// Purpose: Shared constants and types for the low-power state indicator block
// Assumes: 25 MHz device clock, synchronous active-high reset
// Notes:   Times are kept in their own units and turned into cycle counts here
`default_nettype none
package lp_state_pkg;

  localparam int CLK_HZ          = 25_000_000;
  // Idle time before suspend, microseconds
  localparam int SUSPEND_IDLE_US = 3_000;
  // Longer than 3 ms means strictly more cycles than the figure
  localparam int SUSPEND_IDLE_CYC = (SUSPEND_IDLE_US * (CLK_HZ / 1_000_000)) + 1;
  localparam int IDLE_CNT_W      = 18;
  localparam int GPIO_N          = 8;

  localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_RST = 18'h0_0000;
  localparam logic [GPIO_N-1:0]     GPIO_RST     = 8'h00;

  typedef enum logic [2:0] {
    ST_UNCONF  = 3'b001,
    ST_ACTIVE  = 3'b010,
    ST_SUSPEND = 3'b100
  } lp_state_type;

  typedef struct packed {
    logic busIdle;
    logic resumeDet;
    logic resumeGen;
    logic busReset;
    logic configDone;
  } bus_events_type;

  typedef struct packed {
    logic [GPIO_N-1:0] dir;
    logic [GPIO_N-1:0] level;
  } gpio_cfg_type;

endpackage
`default_nettype wire

/* verilog/idle_detect.sv */
// Purpose: Counts continuous bus idle and flags a suspend request
// Assumes: busIdle already synchronised to clk
// Notes:   Flag is a level, held while idle continues past the limit
`default_nettype none
module idle_detect
  import lp_state_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Bus state
  input  wire logic busIdle,
  output var  logic suspendSeen
);

  typedef struct packed {
    logic [IDLE_CNT_W-1:0] cnt;
    logic                  seen;
  } idle_state_type;

  idle_state_type st_ff;
  idle_state_type nxt_st;

  localparam logic [IDLE_CNT_W-1:0] LIMIT = IDLE_CNT_W'(SUSPEND_IDLE_CYC);

  always_comb begin
    nxt_st = st_ff;
    if (!busIdle) begin
      nxt_st.cnt  = IDLE_CNT_RST;
      nxt_st.seen = 1'b0;
    end else if (st_ff.cnt == LIMIT) begin
      nxt_st.seen = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{cnt: IDLE_CNT_RST, seen: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign suspendSeen = st_ff.seen;

endmodule // idle_detect
`default_nettype wire

/* verilog/usb_low_power_state_indicator.sv */
// Purpose: Tracks the USB low-power state and drives the two state indicators
// Assumes: Bus event inputs come from the USB core on clk; busIdle is a raw line
// Notes:   Pads resolve tri-state and the weak pull to io_supply_rail
//
// Operation
// - Suspend signaling moves device into low power
// - Entering low power asserts both indicators
// - After reset indicators held until configuration done
// - Active-high indicator one when suspended or unconfigured, else zero
// - Active-low indicator always complements active-high
// - Resume, bus reset, device reset leave suspend
// - Indicator drivers disabled during reset, weak pull
// - General-purpose pins hold state while suspended
`default_nettype none
module usb_low_power_state_indicator
  import lp_state_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // USB core events
  input  wire bus_events_type busEvents,
  // GPIO configuration from the core
  input  wire gpio_cfg_type gpioCfgIn,
  input  wire logic         gpioCfgWrite,
  // Indicator pads
  output var  logic         suspendOut,
  output var  logic         suspendOutEn,
  output var  logic         suspendN,
  output var  logic         suspendNEn,
  // Held GPIO configuration and low-power flag
  output var  gpio_cfg_type gpioCfgOut,
  output var  logic         lowPower
);

  // ****************************************
  // Input synchronisation and idle detect
  // ****************************************
  typedef struct packed {
    logic         idleMeta;
    logic         idleSync;
    lp_state_type state;
    logic         ind;
    logic         indN;
    logic         drvEn;
    gpio_cfg_type gpio;
  } top_state_type;

  top_state_type st_ff;
  top_state_type nxt_st;
  logic          suspendSeen;

  idle_detect u_idle (
    .clk         (clk),
    .rst         (rst),
    .busIdle     (st_ff.idleSync),
    .suspendSeen (suspendSeen)
  );

  // ****************************************
  // State machine and indicators
  // ****************************************
  always_comb begin
    nxt_st          = st_ff;
    // Raw line only feeds the first stage
    nxt_st.idleMeta = busEvents.busIdle;
    nxt_st.idleSync = st_ff.idleMeta;
    nxt_st.drvEn    = 1'b1;
    case (st_ff.state)
      ST_UNCONF: begin
        if (busEvents.configDone) begin
          nxt_st.state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (suspendSeen && !busEvents.busReset) begin
          nxt_st.state = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (busEvents.resumeDet || busEvents.resumeGen || busEvents.busReset) begin
          nxt_st.state = ST_ACTIVE;
        end
      end
      default: begin
        nxt_st.state = ST_UNCONF;
      end
    endcase
    nxt_st.ind = (nxt_st.state != ST_ACTIVE);
    // complement in its own flop, so the pin has no gate after it
    nxt_st.indN = ~nxt_st.ind;
    if (gpioCfgWrite && nxt_st.state != ST_SUSPEND && st_ff.state != ST_SUSPEND) begin
      nxt_st.gpio = gpioCfgIn;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{idleMeta: 1'b0, idleSync: 1'b0, state: ST_UNCONF, ind: 1'b1,
                 indN: 1'b0, drvEn: 1'b0, gpio: '{dir: GPIO_RST, level: GPIO_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign suspendOut   = st_ff.ind;
  assign suspendN     = st_ff.indN;
  assign suspendOutEn = st_ff.drvEn;
  assign suspendNEn   = st_ff.drvEn;
  assign gpioCfgOut   = st_ff.gpio;
  assign lowPower     = st_ff.ind;

endmodule // usb_low_power_state_indicator
`default_nettype wire

/* tb/usb_host_model.sv */
// Purpose: Host side, drives bus idle and event lines
// Assumes: Bench sets idle and pulse after each edge
// Notes:   Events leave on the next edge, as from a core
`default_nettype none
module usb_host_model import lp_state_pkg::*; (
  input  wire logic           clk,
  input  wire logic           idle,
  input  wire logic [3:0]     pulse,
  output var  bus_events_type busEvents
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk) begin
    busEvents <= {idle, pulse};
  end
endmodule // usb_host_model
`default_nettype wire

/* tb/lp_state_asserts.sv */
// Purpose: Port assertions of the indicator block
// Assumes: One clock, synchronous reset
// Notes:   Reset checks are not disabled by reset
`default_nettype none
module lp_state_asserts import lp_state_pkg::*; (
  input wire logic           clk, rst, gpioCfgWrite, lowPower,
  input wire logic           suspendOut, suspendOutEn, suspendN, suspendNEn,
  input wire bus_events_type busEvents,
  input wire gpio_cfg_type   gpioCfgIn, gpioCfgOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  pin_pair_a:
    assert property (suspendN == ~suspendOut) else $error("pin pair");
  en_pair_a:
    assert property (suspendNEn == suspendOutEn) else $error("enables");
  reset_hiz_a:
    assert property (disable iff (1'b0) rst |=> !suspendOutEn && suspendOut) else $error("hiz");
  drive_up_a:
    assert property (!rst |=> suspendOutEn) else $error("drive");
  lp_mirror_a:
    assert property (lowPower == suspendOut) else $error("mirror");
  idle_entry_a:
    assert property ($rose(suspendOut) && !$past(rst) |-> $past(busEvents.busIdle))
      else $error("entry");
  hold_low_a:
    assert property (suspendOut && !(|busEvents[3:0]) |=> suspendOut) else $error("hold");
  cfg_store_a:
    assert property (gpioCfgWrite && !suspendOut && !busEvents.busIdle |=>
      gpioCfgOut == $past(gpioCfgIn)) else $error("store");
endmodule // lp_state_asserts
bind usb_low_power_state_indicator lp_state_asserts u_chk (.*);
`default_nettype wire

/* tb/test_usb_low_power_state_indicator.sv */
// Purpose: Self-checking bench of the indicator block
// Assumes: Idle limit as set in the package
// Notes:   One suspend only, it fills most of the run
`default_nettype none
module test_usb_low_power_state_indicator import lp_state_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, idle = 0, gpioCfgWrite = 0;
  logic suspendOut, suspendOutEn, suspendN, suspendNEn, lowPower;
  logic [3:0] pulse = 0;
  gpio_cfg_type gpioCfgIn = 0, gpioCfgOut;
  bus_events_type busEvents;
  int errTotal = 0, comparisons = 0, cyc = 0;
  always #20 clk = ~clk;
  usb_host_model u_host (.*);
  usb_low_power_state_indicator u_dut (.*);
  task step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task results;
    if (errTotal == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task s_reset;
    rst = 1;
    step(20);
    chk({suspendOutEn, suspendNEn, suspendOut, suspendN}, 4'h2);
    chk(gpioCfgOut, 16'h0000);
    rst = 0;
    step(1);
    chk({suspendOutEn, suspendNEn, suspendOut, lowPower}, 4'hf);
  endtask
  task s_config;
    pulse = 4'h1;
    step(1);
    pulse = 4'h0;
    chk(suspendOut, 16'h0001);
    step(1);
    chk({suspendOut, suspendN, lowPower}, 3'h2);
  endtask
  task s_gpio(logic [15:0] v, logic [15:0] e);
    gpioCfgIn = v;
    gpioCfgWrite = 1;
    step(1);
    gpioCfgWrite = 0;
    chk(gpioCfgOut, e);
  endtask
  task s_suspend;
    int n;
    n = 0;
    idle = 1;
    while (suspendOut !== 1'b1 && n < 80000) begin
      step(1);
      n++;
    end
    chk(n > SUSPEND_IDLE_CYC && n < SUSPEND_IDLE_CYC + 8, 16'h0001);
    chk({suspendN, lowPower}, 2'h1);
    s_gpio(16'hffff, 16'h5ac3);
    idle = 0;
    pulse = 4'h8;
    step(2);
    pulse = 4'h0;
    chk({suspendOut, suspendN}, 2'h1);
  endtask
  // Run is about 75k cycles, so the cut-off at 90000 sits about 15k cycles past it
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errTotal++;
      results;
    end
  end
  initial begin
    s_reset;
    s_config;
    s_gpio(16'h5ac3, 16'h5ac3);
    s_suspend;
    s_reset;
    results;
  end
endmodule // test_usb_low_power_state_indicator
`default_nettype wire
